// ---- rtl/uart_port_map.vh ----
/*
  Constants for the single-channel UART host port: register offsets, field
  positions, reset values and timing counts. Assumes an 8 ns master clock.
*/
`ifndef UART_PORT_MAP_VH
`define UART_PORT_MAP_VH
// Register offsets on the 3-bit host address
`define ADR_DATA      3'h0
`define ADR_IER       3'h1
`define ADR_FCR       3'h2
`define ADR_LCR       3'h3
`define ADR_MCR       3'h4
`define ADR_LSR       3'h5
`define ADR_MSR       3'h6
`define ADR_SCR       3'h7
// Reset values, bank key and flow control characters
`define RST_ZERO      8'h00
`define RST_DIV_LO    8'h01
`define EBANK_KEY     8'hBF
`define XON_CHAR      8'h11
`define XOFF_CHAR     8'h13
// Field positions
`define LCR_DLAB      7
`define FCR_EN        0
`define FCR_RXCLR     1
`define FCR_TXCLR     2
`define IER_RX        0
`define IER_TX        1
`define MCR_DTR       0
`define MCR_RTS       1
`define MCR_XANY      5
`define MCR_PRESC     7
`define EFR_SWFC      3
`define EFR_ACTS      7
`define FEATURE_CONTROL_REG_AUTODIR  5
// Interrupt status codes
`define ISR_NONE      8'h01
`define ISR_THRE      8'h02
`define ISR_RXLVL     8'h04
`define ISR_RXTMO     8'h0C
// Trigger levels selected by the FIFO control fields
`define RXT0          5'h01
`define RXT1          5'h04
`define RXT2          5'h08
`define RXT3          5'h0E
`define TXT0          5'h01
`define TXT1          5'h04
`define TXT2          5'h08
`define TXT3          5'h0C
// Timing
`define RST_PULSE_NS   40
`define MCLK_PERIOD_NS 8
`define RST_CYC ((`RST_PULSE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define RX_TMO_BITS   6'h28
`endif

// ---- rtl/uart_fifo.v ----
/*
  16 x 8 synchronous FIFO with level count. Assumes push is never issued
  when full and pop never when empty; the caller checks the flags.
*/
`timescale 1ns/1ps
module uart_fifo (
  input  wire       i_clk,
  input  wire       i_arst_n,
  input  wire       i_ce,
  input  wire       i_clr,
  input  wire       i_push,
  input  wire [7:0] i_wdata,
  input  wire       i_pop,
  output wire [7:0] o_rdata,
  output wire [4:0] o_count,
  output wire       o_full
);
  reg [7:0] mem [0:15];
  reg [3:0] wp_q;
  reg [3:0] rp_q;
  reg [4:0] cnt_q;

  assign o_rdata = mem[rp_q];
  assign o_count = cnt_q;
  assign o_full  = cnt_q[4];

  // Pointer and level bookkeeping
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wp_q  <= 4'h0;
      rp_q  <= 4'h0;
      cnt_q <= 5'h00;
    end
    else if (i_ce)
    begin
      if (i_clr)
      begin
        wp_q  <= 4'h0;
        rp_q  <= 4'h0;
        cnt_q <= 5'h00;
      end
      else
      begin
        if (i_push)
          wp_q <= wp_q + 4'h1;
        if (i_pop)
          rp_q <= rp_q + 4'h1;
        if (i_push && !i_pop)
          cnt_q <= cnt_q + 5'h01;
        else if (i_pop && !i_push)
          cnt_q <= cnt_q - 5'h01;
      end
    end
  end

  // Storage, no reset needed
  always @(posedge i_clk)
  begin
    if (i_ce && i_push && !i_clr)
      mem[wp_q] <= i_wdata;
  end
endmodule

// ---- rtl/uart_baud.v ----
/*
  Baud generator: prescaler of 1 or 4, then a 16-bit integer divisor with a
  4-bit fraction in sixteenths. Emits a one-cycle sampling tick.
*/
`timescale 1ns/1ps
module uart_baud (
  input  wire        i_clk,
  input  wire        i_arst_n,
  input  wire        i_ce,
  input  wire        i_clr,
  input  wire        i_presc4,
  input  wire [15:0] i_div_int,
  input  wire [3:0]  i_div_frac,
  output reg         o_tick
);
  reg  [1:0]  pre_q;
  reg  [15:0] cnt_q;
  reg  [3:0]  acc_q;
  wire        pre_tick = !i_presc4 || (pre_q == 2'h3);
  wire [4:0]  acc_sum  = {1'b0, acc_q} + {1'b0, i_div_frac};
  // A zero divisor behaves as one
  wire [15:0] div_m1   = (i_div_int == 16'h0000) ? 16'h0000 : i_div_int - 16'h0001;

  // Fraction carry stretches one period by one prescaled clock cycle
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pre_q  <= 2'h0;
      cnt_q  <= 16'h0000;
      acc_q  <= 4'h0;
      o_tick <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_clr)
      begin
        pre_q  <= 2'h0;
        cnt_q  <= 16'h0000;
        acc_q  <= 4'h0;
        o_tick <= 1'b0;
      end
      else
      begin
        pre_q  <= i_presc4 ? pre_q + 2'h1 : 2'h0;
        o_tick <= 1'b0;
        if (pre_tick)
        begin
          if (cnt_q == 16'h0000)
          begin
            o_tick <= 1'b1;
            acc_q  <= acc_sum[3:0];
            cnt_q  <= div_m1 + {15'h0000, acc_sum[4]};
          end
          else
            cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end
endmodule

// ---- rtl/uart_port.v ----
/*
  Single-channel UART with host register port, 16-byte FIFOs, serial engine
  and interrupt pins. Host pins are sampled on I_MCLK, which also stands in
  for the oscillator input that feeds the baud generator.
  Assumes all host pins are synchronous to I_MCLK and that the reset pin
  is held active for longer than five clock periods.
*/
`timescale 1ns/1ps
`include "uart_port_map.vh"
module uart_port (
  input  wire       I_MCLK,
  input  wire       I_ARST_N,
  input  wire       I_CE,
  input  wire       I_RESET_PIN,
  input  wire       I_BUS_SEL,
  input  wire       I_CS_N,
  input  wire       I_READ_STROBE_N,
  input  wire       I_WRITE_STROBE_N,
  input  wire       I_RW_SEL,
  input  wire [2:0] I_ADDR,
  input  wire [7:0] I_DATA,
  input  wire       I_RX,
  input  wire       I_CTS_N,
  input  wire       I_DSR_N,
  input  wire       I_CD_N,
  input  wire       I_RI_N,
  output reg  [7:0] O_DATA,
  output reg        O_DATA_OE,
  output reg        O_TX,
  output reg        O_RTS_N,
  output reg        O_DTR_N,
  output reg        O_INT,
  output reg        O_TX_INT,
  output reg        O_TX_INT_INV
);
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_START = 4'b0010;
  localparam [3:0] S_DATA  = 4'b0100;
  localparam [3:0] S_STOP  = 4'b1000;
  localparam [31:0] RST_CYC_W = `RST_CYC;
  localparam [2:0]  RST_CYC   = RST_CYC_W[2:0];  // Count fits three bits

  // Reset pin filter: polarity follows the bus style
  reg  [2:0] rst_cnt_q;
  wire       rst_pin_act = I_BUS_SEL ? I_RESET_PIN : !I_RESET_PIN;
  wire       srst = rst_pin_act && (rst_cnt_q == RST_CYC);
  always @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      rst_cnt_q <= 3'h0;
    else if (I_CE)
      rst_cnt_q <= !rst_pin_act ? 3'h0 : (srst ? rst_cnt_q : rst_cnt_q + 3'h1);
  end

  // Bus cycle framing by chip select and strobes or select line
  wire rd_act = !I_CS_N && (I_BUS_SEL ? !I_READ_STROBE_N : I_RW_SEL);
  wire wr_act = !I_CS_N && (I_BUS_SEL ? !I_WRITE_STROBE_N : !I_RW_SEL);
  reg  rd_act_q;
  reg  wr_act_q;
  reg  [2:0] rd_adr_q;
  wire wr_go   = wr_act && !wr_act_q;
  wire rd_done = rd_act_q && !rd_act;

  // Register file
  reg  [7:0] ier_q, fcr_q, lcr_q, mcr_q, scr_q, efr_q, feature_control_reg_q;
  reg  [7:0] div_lo_q, div_hi_q, dld_q;
  reg        oe_q, fe_q, xoff_q, tmo_q;
  wire       dlab  = lcr_q[`LCR_DLAB];
  wire       ebank = (lcr_q == `EBANK_KEY);
  wire       fen   = fcr_q[`FCR_EN];

  // FIFO wiring
  wire [7:0] tx_head, rx_head;
  wire [4:0] tx_cnt, rx_cnt;
  wire       tx_full, rx_full;
  wire       tx_pop;
  wire       rx_done;
  wire [7:0] rx_byte;
  wire       fcr_wr  = wr_go && (I_ADDR == `ADR_FCR) && !ebank && !dlab;
  wire       fen_chg = fcr_wr && (I_DATA[`FCR_EN] != fen);
  wire       tx_clr  = srst || fen_chg || (fcr_wr && I_DATA[`FCR_TXCLR]);
  wire       rx_clr  = srst || fen_chg || (fcr_wr && I_DATA[`FCR_RXCLR]);
  // With FIFOs off each side holds a single byte
  wire       tx_room = fen ? !tx_full : (tx_cnt == 5'h00);
  wire       rx_room = fen ? !rx_full : (rx_cnt == 5'h00);
  wire       tx_push = wr_go && (I_ADDR == `ADR_DATA) && !dlab && tx_room;
  wire       rx_push = rx_done && rx_room;
  wire       rx_pop  = rd_done && (rd_adr_q == `ADR_DATA) && !dlab && (rx_cnt != 5'h00);

  uart_fifo u_tx_fifo (
    .i_clk    (I_MCLK),
    .i_arst_n (I_ARST_N),
    .i_ce     (I_CE),
    .i_clr    (tx_clr),
    .i_push   (tx_push),
    .i_wdata  (I_DATA),
    .i_pop    (tx_pop),
    .o_rdata  (tx_head),
    .o_count  (tx_cnt),
    .o_full   (tx_full)
  );
  uart_fifo u_rx_fifo (
    .i_clk    (I_MCLK),
    .i_arst_n (I_ARST_N),
    .i_ce     (I_CE),
    .i_clr    (rx_clr),
    .i_push   (rx_push),
    .i_wdata  (rx_byte),
    .i_pop    (rx_pop),
    .o_rdata  (rx_head),
    .o_count  (rx_cnt),
    .o_full   (rx_full)
  );

  // Baud tick from the prescaled input clock
  wire tick;
  uart_baud u_baud (
    .i_clk      (I_MCLK),
    .i_arst_n   (I_ARST_N),
    .i_ce       (I_CE),
    .i_clr      (srst),
    .i_presc4   (mcr_q[`MCR_PRESC]),
    .i_div_int  ({div_hi_q, div_lo_q}),
    .i_div_frac (dld_q[3:0]),
    .o_tick     (tick)
  );

  // Sampling ratio 16X, 8X or 4X
  reg [4:0] os_len;
  always @*
  begin
    case (dld_q[5:4])
      2'h1:    os_len = 5'h08;
      2'h2:    os_len = 5'h04;
      default: os_len = 5'h10;
    endcase
  end
  wire [4:0] os_last = os_len - 5'h01;
  wire [2:0] nb_last = {1'b1, lcr_q[1:0]};

  // Trigger levels and interrupt conditions
  reg [4:0] rx_trig, tx_trig;
  always @*
  begin
    case (fcr_q[7:6])
      2'h0:    rx_trig = `RXT0;
      2'h1:    rx_trig = `RXT1;
      2'h2:    rx_trig = `RXT2;
      default: rx_trig = `RXT3;
    endcase
    case (fcr_q[5:4])
      2'h0:    tx_trig = `TXT0;
      2'h1:    tx_trig = `TXT1;
      2'h2:    tx_trig = `TXT2;
      default: tx_trig = `TXT3;
    endcase
  end
  wire rx_lvl  = fen ? (rx_cnt >= rx_trig) || tmo_q : (rx_cnt != 5'h00);
  wire tx_busy = fen ? (tx_cnt > tx_trig) : (tx_cnt != 5'h00);
  wire rx_irq  = rx_lvl && ier_q[`IER_RX];
  wire tx_irq  = !tx_busy && ier_q[`IER_TX];
  wire [7:0] irq_status_reg = {fen, fen, 6'h00} |
                   (tmo_q && rx_irq ? `ISR_RXTMO :
                    rx_irq ? `ISR_RXLVL : tx_irq ? `ISR_THRE : `ISR_NONE);
  wire       tx_st_idle;
  wire [7:0] line_status_reg = {1'b0, (tx_cnt == 5'h00) && tx_st_idle, tx_cnt == 5'h00,
                    1'b0, fe_q, 1'b0, oe_q, rx_cnt != 5'h00};
  wire [7:0] modem_status_reg = {!I_CD_N, !I_RI_N, !I_DSR_N, !I_CTS_N, 4'h0};

  // Read data selection
  reg [7:0] rdata;
  always @*
  begin
    case (I_ADDR)
      `ADR_DATA: rdata = dlab ? div_lo_q : rx_head;
      `ADR_IER:  rdata = dlab ? div_hi_q : ier_q;
      `ADR_FCR:  rdata = ebank ? efr_q : (dlab ? dld_q : irq_status_reg);
      `ADR_LCR:  rdata = lcr_q;
      `ADR_MCR:  rdata = mcr_q;
      `ADR_LSR:  rdata = line_status_reg;
      `ADR_MSR:  rdata = ebank ? feature_control_reg_q : modem_status_reg;
      default:   rdata = ebank ? {3'h0, rx_cnt} : scr_q;
    endcase
  end

  // Host writes and status flags; hardware sets win over read clears
  wire lsr_rd = rd_done && (rd_adr_q == `ADR_LSR);
  wire fe_set;
  reg  [5:0] tmo_cnt_q;
  reg  [4:0] bt_cnt_q;
  always @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      {ier_q, fcr_q, lcr_q, mcr_q} <= {4{`RST_ZERO}};
      {scr_q, efr_q, feature_control_reg_q, div_hi_q, dld_q} <= {5{`RST_ZERO}};
      div_lo_q <= `RST_DIV_LO;
      {oe_q, fe_q, tmo_q, rd_act_q, wr_act_q} <= 5'h00;
      rd_adr_q <= 3'h0;
      tmo_cnt_q <= 6'h00;
      bt_cnt_q <= 5'h00;
    end
    else if (I_CE)
    begin
      if (srst)
      begin
        {ier_q, fcr_q, lcr_q, mcr_q} <= {4{`RST_ZERO}};
        {scr_q, efr_q, feature_control_reg_q, div_hi_q, dld_q} <= {5{`RST_ZERO}};
        div_lo_q <= `RST_DIV_LO;
        {oe_q, fe_q, tmo_q, rd_act_q, wr_act_q} <= 5'h00;
        tmo_cnt_q <= 6'h00;
        bt_cnt_q <= 5'h00;
      end
      else
      begin
        rd_act_q <= rd_act;
        wr_act_q <= wr_act;
        if (rd_act)
          rd_adr_q <= I_ADDR;
        if (wr_go)
        begin
          case (I_ADDR)
            `ADR_DATA: if (dlab) div_lo_q <= I_DATA;
            `ADR_IER:  if (dlab) div_hi_q <= I_DATA; else ier_q <= I_DATA;
            `ADR_FCR:  if (ebank) efr_q <= I_DATA; else if (dlab) dld_q <= I_DATA;
                       else fcr_q <= {I_DATA[7:3], 2'h0, I_DATA[0]};
            `ADR_LCR:  lcr_q <= I_DATA;
            `ADR_MCR:  mcr_q <= I_DATA;
            `ADR_MSR:  if (ebank) feature_control_reg_q <= I_DATA;
            `ADR_SCR:  if (!ebank) scr_q <= I_DATA;
            default:   scr_q <= scr_q;
          endcase
        end
        oe_q <= (rx_done && !rx_room) || (oe_q && !lsr_rd);
        fe_q <= fe_set || (fe_q && !lsr_rd);
        // Receive timeout after forty idle bit times with data waiting and FIFOs enabled
        bt_cnt_q <= !tick ? bt_cnt_q : (bt_cnt_q >= os_last ? 5'h00 : bt_cnt_q + 5'h01);
        if (rx_done || rx_pop || rx_cnt == 5'h00 || !fen)
        begin
          tmo_cnt_q <= 6'h00;
          tmo_q <= 1'b0;
        end
        else if (tick && bt_cnt_q >= os_last && tmo_cnt_q != `RX_TMO_BITS)
          tmo_cnt_q <= tmo_cnt_q + 6'h01;
        else if (tmo_cnt_q == `RX_TMO_BITS)
          tmo_q <= 1'b1;
      end
    end
  end

  // Transmitter: halted by received stop character or by clear-to-send
  reg  [3:0] tx_st_q;
  reg  [7:0] tx_sh_q;
  reg  [4:0] tx_os_q;
  reg  [2:0] tx_idx_q;
  wire tx_halt = (efr_q[`EFR_SWFC] && xoff_q) || (efr_q[`EFR_ACTS] && I_CTS_N);
  assign tx_st_idle = (tx_st_q == S_IDLE);
  assign tx_pop = tx_st_idle && !tx_halt && (tx_cnt != 5'h00) && !tx_clr;
  wire tx_end = tick && (tx_os_q == os_last);
  always @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      tx_st_q <= S_IDLE;
      tx_sh_q <= 8'h00;
      tx_os_q <= 5'h00;
      tx_idx_q <= 3'h0;
      O_TX <= 1'b1;
    end
    else if (I_CE)
    begin
      if (srst)
      begin
        tx_st_q <= S_IDLE;
        O_TX <= 1'b1;
      end
      else
      begin
        if (tick)
          tx_os_q <= (tx_os_q == os_last) ? 5'h00 : tx_os_q + 5'h01;
        case (tx_st_q)
          S_IDLE:
            if (tx_pop)
            begin
              tx_sh_q <= tx_head;
              tx_os_q <= 5'h00;
              tx_idx_q <= 3'h0;
              O_TX <= 1'b0;
              tx_st_q <= S_START;
            end
          S_START:
            if (tx_end)
            begin
              O_TX <= tx_sh_q[0];
              tx_st_q <= S_DATA;
            end
          S_DATA:
            if (tx_end)
            begin
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              tx_idx_q <= tx_idx_q + 3'h1;
              O_TX <= (tx_idx_q == nb_last) ? 1'b1 : tx_sh_q[1];
              if (tx_idx_q == nb_last)
                tx_st_q <= S_STOP;
            end
          S_STOP:
            if (tx_end)
              tx_st_q <= S_IDLE;
          default:
            tx_st_q <= S_IDLE;
        endcase
      end
    end
  end

  // Receiver: samples mid-bit; a low start sample must persist to mid-bit
  reg  [3:0] rx_st_q;
  reg  [7:0] rx_sh_q;
  reg  [4:0] rx_os_q;
  reg  [2:0] rx_idx_q;
  wire [4:0] rx_lim = (rx_st_q == S_START) ? {1'b0, os_len[4:1]} - 5'h01 : os_last;
  wire rx_smp = tick && (rx_os_q == rx_lim);
  assign rx_done = (rx_st_q == S_STOP) && rx_smp;
  assign fe_set  = rx_done && !I_RX;
  assign rx_byte = rx_sh_q >> (2'h3 - lcr_q[1:0]);
  always @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      rx_st_q <= S_IDLE;
      rx_sh_q <= 8'h00;
      rx_os_q <= 5'h00;
      rx_idx_q <= 3'h0;
      xoff_q <= 1'b0;
    end
    else if (I_CE)
    begin
      if (srst)
      begin
        rx_st_q <= S_IDLE;
        xoff_q <= 1'b0;
      end
      else
      begin
        if (tick)
          rx_os_q <= rx_smp ? 5'h00 : rx_os_q + 5'h01;
        case (rx_st_q)
          S_IDLE:
            if (!I_RX)
            begin
              rx_os_q <= 5'h00;
              rx_idx_q <= 3'h0;
              rx_st_q <= S_START;
            end
          S_START:
            if (rx_smp)
              rx_st_q <= I_RX ? S_IDLE : S_DATA;
          S_DATA:
            if (rx_smp)
            begin
              rx_sh_q <= {I_RX, rx_sh_q[7:1]};
              rx_idx_q <= rx_idx_q + 3'h1;
              if (rx_idx_q == nb_last)
                rx_st_q <= S_STOP;
            end
          S_STOP:
            if (rx_smp)
              rx_st_q <= S_IDLE;
          default:
            rx_st_q <= S_IDLE;
        endcase
        // Software flow control on received characters
        if (rx_done && efr_q[`EFR_SWFC])
        begin
          if (rx_byte == `XOFF_CHAR)
            xoff_q <= 1'b1;
          else if (rx_byte == `XON_CHAR || mcr_q[`MCR_XANY])
            xoff_q <= 1'b0;
        end
      end
    end
  end

  // Registered pins: data bus, modem lines and interrupt levels
  always @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_DATA <= 8'h00;
      O_DATA_OE <= 1'b0;
      O_RTS_N <= 1'b1;
      O_DTR_N <= 1'b1;
      O_INT <= 1'b0;
      O_TX_INT <= 1'b1;
      O_TX_INT_INV <= 1'b0;
    end
    else if (I_CE)
    begin
      if (srst)
      begin
        O_DATA_OE <= 1'b0;
        O_RTS_N <= 1'b1;
        O_DTR_N <= 1'b1;
        O_INT <= !I_BUS_SEL;
        O_TX_INT <= 1'b1;
        O_TX_INT_INV <= 1'b0;
      end
      else
      begin
        O_DATA <= rdata;
        O_DATA_OE <= rd_act;
        // Automatic direction: drive while a character is on the line
        O_RTS_N <= feature_control_reg_q[`FEATURE_CONTROL_REG_AUTODIR] ? tx_st_idle : !mcr_q[`MCR_RTS];
        O_DTR_N <= !mcr_q[`MCR_DTR];
        O_INT <= (rx_irq || tx_irq) ^ !I_BUS_SEL;
        O_TX_INT <= !tx_busy;
        O_TX_INT_INV <= tx_busy;
      end
    end
  end
endmodule

// ---- test/uart_port_sva.sv ----
/* Checker for uart_port pins: read enable timing, reset-pin defaults and
   interrupt pin relations. Assumes every input is synchronous to I_MCLK. */
`timescale 1ns/1ps
module uart_port_chk (
  input wire logic I_MCLK, I_ARST_N, I_CE, I_RESET_PIN, I_BUS_SEL,
  input wire logic I_CS_N, I_READ_STROBE_N, I_WRITE_STROBE_N, I_RW_SEL,
  input wire logic O_DATA_OE, O_TX, O_RTS_N, O_DTR_N,
  input wire logic O_INT, O_TX_INT, O_TX_INT_INV
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);
  // Decoded host cycles in either bus style
  wire rd_on = !I_CS_N && (I_BUS_SEL ? !I_READ_STROBE_N : I_RW_SEL);
  wire wr_on = !I_CS_N && (I_BUS_SEL ? !I_WRITE_STROBE_N : !I_RW_SEL);
  // Reset pin held active long enough in each style
  sequence hi_pin_s;
    (I_CE && I_BUS_SEL && I_RESET_PIN)[*8];
  endsequence
  sequence lo_pin_s;
    (I_CE && !I_BUS_SEL && !I_RESET_PIN)[*8];
  endsequence
  sequence release_s;
    !$past(I_ARST_N) && I_ARST_N;
  endsequence
  oe_on_a: assert property (rd_on |=> O_DATA_OE)
    else $error("read enable missing");
  oe_off_a: assert property (!rd_on |=> !O_DATA_OE)
    else $error("read enable left on");
  pin_rst_hi_a: assert property (hi_pin_s |=> O_TX && O_RTS_N && O_DTR_N && !O_INT)
    else $error("strobe style reset defaults wrong");
  pin_rst_lo_a: assert property (lo_pin_s |=> O_TX && O_INT)
    else $error("select style reset defaults wrong");
  tx_rst_idle_a: assert property (hi_pin_s |=> O_TX_INT && !O_TX_INT_INV)
    else $error("transmit pins not idle in reset");
  inv_pair_a: assert property (O_TX_INT_INV == !O_TX_INT)
    else $error("transmit pins not inverse");
  tx_cause_a: assert property ($fell(O_TX_INT) |-> $past(wr_on) || $past(wr_on, 2) || $past(wr_on, 3))
    else $error("transmit pin fell without a write");
  rel_int_a: assert property (release_s |=> O_INT == !I_BUS_SEL)
    else $error("interrupt idle level wrong");
endmodule
bind uart_port uart_port_chk chk_u (.I_MCLK, .I_ARST_N, .I_CE, .I_RESET_PIN, .I_BUS_SEL,
  .I_CS_N, .I_READ_STROBE_N, .I_WRITE_STROBE_N, .I_RW_SEL, .O_DATA_OE, .O_TX,
  .O_RTS_N, .O_DTR_N, .O_INT, .O_TX_INT, .O_TX_INT_INV);

// ---- test/host_bus_model.sv ----
/* Host bus master model: runs one register cycle in either bus style.
   Assumes the caller lets each call return before the next one. */
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       clk,
  input  wire logic       style,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            rw,
  output logic [2:0]      adr,
  output logic [7:0]      dat
);
  // Idle bus at time zero
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    rw   = 1'b1;
    adr  = 3'h0;
    dat  = 8'h00;
  end
  // One cycle: request held three edges, then two idle edges
  task automatic cyc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    adr  = a;
    dat  = d;
    rw   = ~w;
    cs_n = 1'b0;
    rd_n = ~(style & ~w);
    wr_n = ~(style & w);
    repeat (3) @(posedge clk);
    #1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    rw   = 1'b1;
    dat  = ~d; // Released lines must not keep the old value
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule

// ---- test/uart_port_tb_top.sv ----
/* Self-checking bench for uart_port: register cycles through the host
   model, serial bytes on the receive line and pin level checks.
   Assumes the default divisor of 1, so one bit lasts 16 clocks. */
`timescale 1ns/1ps
`include "uart_port_map.vh"
module uart_port_tb_top;
  logic       mclk, arst_n, style, rst_pin, rx_line, oe_q;
  wire        cs_n, rd_n, wr_n, rw, oe, tx, rts_n, dtr_n, int_pin, tx_int, tx_int_inv;
  wire  [2:0] adr;
  wire  [7:0] dat, o_data;
  logic [7:0] exp_q[$];
  logic [7:0] tx_q[$];
  logic [7:0] tx_got, tx_exp;
  logic [7:0] d;
  int         mismatches, n_compared, seed, n, k;
  uart_port dut_u (.I_MCLK(mclk), .I_ARST_N(arst_n), .I_CE(1'b1), .I_RESET_PIN(rst_pin),
    .I_BUS_SEL(style), .I_CS_N(cs_n), .I_READ_STROBE_N(rd_n), .I_WRITE_STROBE_N(wr_n),
    .I_RW_SEL(rw), .I_ADDR(adr), .I_DATA(dat), .I_RX(rx_line), .I_CTS_N(1'b1),
    .I_DSR_N(1'b1), .I_CD_N(1'b1), .I_RI_N(1'b1), .O_DATA(o_data), .O_DATA_OE(oe),
    .O_TX(tx), .O_RTS_N(rts_n), .O_DTR_N(dtr_n), .O_INT(int_pin), .O_TX_INT(tx_int),
    .O_TX_INT_INV(tx_int_inv));
  host_bus_model host_u (.clk(mclk), .style(style), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .rw(rw), .adr(adr), .dat(dat));
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t pin %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_tx(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t serial %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.cyc(1'b0, a, 8'h00);
  endtask
  // Bounded wait for the transmit pin (which=1) or interrupt pin
  task automatic wait_lvl(input logic which, input logic want);
    n = 0;
    while (((which ? tx_int : int_pin) !== want) && n < 1000)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 1000)
    begin
      mismatches++;
      $display("ERROR %0t wait limit reached", $time);
    end
    #1;
  endtask
  // One frame LSB first: start, 8 data, stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rx_line = f[i];
      tick(16);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Read monitor: oldest note against first cycle of read enable, sampled mid-cycle
  always @(negedge mclk)
  begin
    if (oe === 1'b1 && oe_q !== 1'b1)
      chk_rd(o_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    oe_q <= oe;
  end
  // Serial monitor: mid-bit samples of each frame whose byte was noted
  initial
  begin
    forever
    begin
      @(negedge tx);
      if (tx_q.size())
      begin
        tx_exp = tx_q.pop_front();
        repeat (8) @(negedge mclk);
        for (int i = 0; i < 8; i++)
        begin
          repeat (16) @(negedge mclk);
          tx_got[i] = tx;
        end
        chk_tx(tx_got, tx_exp);
      end
    end
  end
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    wrap_up;
  end
  // Four passes: strobe and select style, FIFOs off and on
  initial
  begin
    seed = 18;
    mismatches = 0;
    n_compared = 0;
    {style, rst_pin, rx_line, arst_n} = 4'b1010;
    tick(6);
    arst_n = 1'b1;
    tick(2);
    chk_pin(tx, 1'b1);
    chk_pin(int_pin, 1'b0);
    chk_pin(tx_int, 1'b1);
    for (k = 0; k < 4; k++)
    begin
      style = ~k[1];
      rst_pin = k[1];
      host_u.cyc(1'b1, `ADR_LCR, 8'h03);
      host_u.cyc(1'b1, `ADR_FCR, {7'h00, k[0]});
      d = $random(seed);
      host_u.cyc(1'b1, `ADR_SCR, d);
      rd(`ADR_SCR, d);
      host_u.cyc(1'b1, `ADR_IER, 8'h01);
      d = $random(seed);
      send(d);
      wait_lvl(1'b0, style);
      chk_pin(int_pin, style);
      rd(`ADR_DATA, d);
      tick(3);
      chk_pin(int_pin, ~style);
      host_u.cyc(1'b1, `ADR_IER, 8'h00);
      host_u.cyc(1'b1, `ADR_MCR, 8'h03);
      chk_pin(rts_n, 1'b0);
      chk_pin(dtr_n, 1'b0);
      for (int j = 0; j < 3; j++)
      begin
        d = $random(seed);
        // Only the first frame completes before the reset pin cuts the next
        if (j == 0)
          tx_q.push_back(d);
        host_u.cyc(1'b1, `ADR_DATA, d);
      end
      chk_pin(tx_int, 1'b0);
      chk_pin(tx_int_inv, 1'b1);
      wait_lvl(1'b1, 1'b1);
      chk_pin(n > 100, 1'b1);
      chk_pin(tx_int_inv, 1'b0);
      rst_pin = style;
      tick(8);
      chk_pin(tx, 1'b1);
      chk_pin(int_pin, ~style);
      rst_pin = ~style;
      tick(3);
      rd(`ADR_SCR, 8'h00);
    end
    tick(4);
    wrap_up;
  end
endmodule
